//--- logic/vint_params.svh
// Constants for the vectored interrupt unit: channel map, sizes and reset values.
// Assumes it is included by the package and by the design modules by bare name.
`ifndef VINT_PARAMS_SVH
`define VINT_PARAMS_SVH

`define VINT_NUM_CHAN      32
`define VINT_CHAN_IDX_W    5
`define VINT_NUM_SLOTS     16
`define VINT_SLOT_IDX_W    4
`define VINT_ADDR_W        32

`define VINT_CH_SOFT       5'h01
`define VINT_CH_TIMER0     5'h04
`define VINT_CH_SERIAL0    5'h06
`define VINT_CH_SERIAL1    5'h07
`define VINT_CH_PWM        5'h08
`define VINT_CH_RTC        5'h0d
`define VINT_CH_EXT0       5'h0e
`define VINT_NUM_EXT       3'h4

`define VINT_MISC_MASK     32'h00041e2d
`define VINT_RESET_REQ     32'h00000000
`define VINT_RESET_ADDR    32'h00000000

`endif

//--- logic/vint_pkg.sv
// Types shared by both ends of the vectored interrupt unit.
// Assumes vint_params.svh is on the include path.
`include "vint_params.svh"

package vint_pkg;

  typedef logic [`VINT_NUM_CHAN-1:0]   vint_chan_t;
  typedef logic [`VINT_CHAN_IDX_W-1:0] vint_chan_idx_t;
  typedef logic [`VINT_SLOT_IDX_W-1:0] vint_slot_idx_t;
  typedef logic [`VINT_ADDR_W-1:0]     vint_addr_t;

  typedef struct packed {
    logic           fast_irq;
    logic           normal_irq;
    logic           vec_active;
    vint_slot_idx_t vec_slot;
    vint_addr_t     vec_addr;
    vint_chan_t     fast_status;
    vint_chan_t     normal_status;
  } vint_ctrl_state_s;

  typedef struct packed {
    vint_chan_t req;
    logic [3:0] ext_meta;
    logic [3:0] ext_sync;
  } vint_src_state_s;

endpackage : vint_pkg

//--- logic/vint_if.sv
// Request lines from the peripheral-side end to the controller end.
// Assumes both ends run on the same clock; the testbench joins them.
`timescale 1ns/1ps
`include "vint_params.svh"

interface vint_if #(
  parameter int NUM_CHAN = `VINT_NUM_CHAN
);
  logic [NUM_CHAN-1:0] req;

  modport src  (output req);
  modport ctrl (input  req);
endinterface : vint_if

//--- logic/vint_or.sv
// Combines a group of peripheral flags into one request level.
// Assumes flags come from logic on the same clock.
`timescale 1ns/1ps

module vint_or #(
  parameter int WIDTH = 4
) (
  input  wire logic [WIDTH-1:0] flags_in,  // Flags of one peripheral.
  output logic                  any_out    // High while any flag is high.
);
  assign any_out = |flags_in;
endmodule : vint_or

//--- logic/vint_src.sv
// Peripheral-side end: merges each peripheral's flags onto its request channel.
// Assumes flags are same-clock logic except the external lines, which are pins.
`timescale 1ns/1ps
`include "vint_params.svh"

module vint_src (
  input  wire logic       clock_in,          // 200 MHz clock.
  input  wire logic       reset_in,          // Synchronous reset, active high.
  input  wire logic [31:0] misc_req_in,      // One line per other peripheral channel.
  input  wire logic [3:0] timer0_match_in,   // match_event_0..3 of the first timer.
  input  wire logic [3:0] serial0_flags_in,  // Line status, tx empty, rx data, timeout.
  input  wire logic [4:0] serial1_flags_in,  // As above plus modem_status_flag.
  input  wire logic [6:0] pwm_match_in,      // Seven match events of the modulator.
  input  wire logic [1:0] rtc_flags_in,      // rtc_increment_flag, rtc_alarm_flag.
  input  wire logic [3:0] ext_irq_lines_in,  // ext_irq_line_0..3, asynchronous pins.
  vint_if.src             link               // Request lines to the controller.
);
  vint_pkg::vint_src_state_s state_r;
  vint_pkg::vint_src_state_s state_nxt;
  logic timer0_any;
  logic serial0_any;
  logic serial1_any;
  logic pwm_any;
  logic rtc_any;

  vint_or #(.WIDTH(4)) u_timer0 (.flags_in(timer0_match_in), .any_out(timer0_any)); // R14
  vint_or #(.WIDTH(4)) u_serial0 (.flags_in(serial0_flags_in), .any_out(serial0_any)); // R15
  vint_or #(.WIDTH(5)) u_serial1 (.flags_in(serial1_flags_in), .any_out(serial1_any)); // R15
  vint_or #(.WIDTH(7)) u_pwm (.flags_in(pwm_match_in), .any_out(pwm_any)); // R16
  vint_or #(.WIDTH(2)) u_rtc (.flags_in(rtc_flags_in), .any_out(rtc_any)); // R17

  always_comb begin
    state_nxt          = state_r;
    state_nxt.ext_meta = ext_irq_lines_in;
    state_nxt.ext_sync = state_r.ext_meta;
    // Only the listed miscellaneous channels pass; the soft channel stays low.
    state_nxt.req = misc_req_in & `VINT_MISC_MASK; // R12 R13
    state_nxt.req[`VINT_CH_TIMER0]  = timer0_any; // R14
    state_nxt.req[`VINT_CH_SERIAL0] = serial0_any; // R15
    state_nxt.req[`VINT_CH_SERIAL1] = serial1_any; // R15
    state_nxt.req[`VINT_CH_PWM]     = pwm_any; // R16
    state_nxt.req[`VINT_CH_RTC]     = rtc_any; // R17
    state_nxt.req[`VINT_CH_EXT0 +: 4] = state_r.ext_sync; // R18
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.req = state_r.req;
endmodule : vint_src

//--- logic/vint_ctrl.sv
// Controller end of the vectored interrupt unit: classifies request channels,
// arbitrates the vectored slots and drives fast and normal requests to the core.
// Assumes request lines come from same-clock logic and that all class settings
// are plain level inputs held by the surrounding system control logic.
//
// Summary of operation
// (R1) Each channel joins exactly one class.
// (R2) Fast class outranks all normal requests.
// (R3) All fast channels merge onto one output.
// (R4) Status word shows requesting fast channels.
// (R5) Sixteen slots, each selects any channel.
// (R6) Lower slot index wins over higher.
// (R7) Non-vectored rank below slots and fast.
// (R8) Normal output high while any normal active.
// (R9) Vector gives winning slot's handler address.
// (R10) Default address when no slot requests.
// (R11) Second status word shows active normal channels.
// (R12) Each peripheral presents one combined line.
// (R13) Soft channel raised by software only.
// (R14) First timer matches arrive on channel 4.
// (R15) Serial ports use channels 6 and 7.
// (R16) Modulator matches arrive on channel 8.
// (R17) Clock increment and alarm on 13.
// (R18) External lines take channels 14 to 17.
// (R19) Fast channels skip normal arbitration.
// (R20) Outputs registered, one cycle after cause.
`timescale 1ns/1ps
`include "vint_params.svh"

module vint_ctrl #(
  parameter int NUM_CHAN  = `VINT_NUM_CHAN,
  parameter int NUM_SLOTS = `VINT_NUM_SLOTS
) (
  input  wire logic                      clock_in,          // 200 MHz clock.
  input  wire logic                      reset_in,          // Synchronous reset, active high.
  vint_if.ctrl                           link,              // Request lines from peripherals.
  input  wire logic                      soft_req_in,       // Software raise of soft channel.
  input  wire vint_pkg::vint_chan_t      fast_select_in,    // 1 puts a channel in fast class.
  input  wire logic [NUM_SLOTS-1:0]      slot_enable_in,    // 1 enables a vectored slot.
  input  wire vint_pkg::vint_chan_idx_t  slot_chan_in  [NUM_SLOTS], // Channel of each slot.
  input  wire vint_pkg::vint_addr_t      slot_addr_in  [NUM_SLOTS], // Handler of each slot.
  input  wire vint_pkg::vint_addr_t      default_addr_in,   // Handler for non-vectored.
  output logic                           fast_irq_out,      // Fast request to the core.
  output logic                           normal_irq_out,    // Normal request to the core.
  output vint_pkg::vint_addr_t           vec_addr_out,      // Vector address word.
  output logic                           vec_active_out,    // A vectored slot is winning.
  output vint_pkg::vint_slot_idx_t       vec_slot_out,      // Index of the winning slot.
  output vint_pkg::vint_chan_t           fast_status_out,   // Requesting fast channels.
  output vint_pkg::vint_chan_t           normal_status_out  // Active normal channels.
);

  vint_pkg::vint_ctrl_state_s state_r;
  vint_pkg::vint_ctrl_state_s state_nxt;

  vint_pkg::vint_chan_t raw_req;
  vint_pkg::vint_chan_t fast_req;
  vint_pkg::vint_chan_t normal_req;
  logic [NUM_SLOTS-1:0] slot_hit;
  logic                 vec_found;
  vint_pkg::vint_slot_idx_t vec_idx;

  // The soft channel is fed only from software; whatever the far end puts on it
  // is dropped so that a miswired peripheral cannot fake a software request.
  always_comb begin
    raw_req                = link.req;
    raw_req[`VINT_CH_SOFT] = soft_req_in; // R13
  end

  // A channel is fast when selected, otherwise normal; the two sets never overlap.
  always_comb begin
    fast_req   = raw_req & fast_select_in; // R1
    normal_req = raw_req & ~fast_select_in; // R19
  end

  // A slot requests when enabled and its channel is an active normal request.
  // A slot pointing at a fast channel therefore never wins.
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    always_comb begin
      slot_hit[s]   = slot_enable_in[s] & normal_req[slot_chan_in[s]]; // R5 R19
    end
  end

  // Search from the top so the lowest requesting index is the one left standing.
  always_comb begin
    vec_found = 1'b0;
    vec_idx   = '0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (slot_hit[s]) begin
        vec_found = 1'b1; // R6
        vec_idx   = vint_pkg::vint_slot_idx_t'(s);
      end
    end
  end

  always_comb begin
    state_nxt               = state_r;
    state_nxt.fast_status   = fast_req; // R4
    state_nxt.normal_status = normal_req; // R11
    state_nxt.fast_irq      = |fast_req; // R2 R3
    // Vectored and non-vectored requests share the one normal output; the fast
    // output is separate and set in the same cycle, so the core can rank the fast class above them.
    state_nxt.normal_irq    = |normal_req; // R7 R8
    state_nxt.vec_active    = vec_found;
    state_nxt.vec_slot      = vec_idx;
    if (vec_found) begin
      state_nxt.vec_addr = slot_addr_in[vec_idx]; // R9
    end else begin
      state_nxt.vec_addr = default_addr_in; // R10 R7
    end
  end

  // Registering the whole state costs one cycle of latency but keeps the
  // outputs glitch free while classes are reprogrammed at run time.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r               <= '0;
      state_r.vec_addr      <= `VINT_RESET_ADDR;
      state_r.fast_status   <= `VINT_RESET_REQ;
      state_r.normal_status <= `VINT_RESET_REQ;
    end else begin
      state_r <= state_nxt; // R20
    end
  end

  assign fast_irq_out      = state_r.fast_irq;
  assign normal_irq_out    = state_r.normal_irq;
  assign vec_addr_out      = state_r.vec_addr;
  assign vec_active_out    = state_r.vec_active;
  assign vec_slot_out      = state_r.vec_slot;
  assign fast_status_out   = state_r.fast_status;
  assign normal_status_out = state_r.normal_status;

endmodule : vint_ctrl

//--- bench/vint_link_sva.sv
// Checker for the request link and the controller outputs of the interrupt unit.
// Assumes one clock; the testbench instantiates it beside the link.
`timescale 1ns/1ps

module vint_link_sva (
  input wire logic                 clock_in,         // Clock.
  input wire logic                 reset_in,         // Sync reset.
  input wire logic [31:0]          req_in,           // Link lines.
  input wire logic                 soft_req_in,      // Soft raise.
  input wire vint_pkg::vint_chan_t fast_select_in,   // Fast class.
  input wire vint_pkg::vint_addr_t default_addr_in,  // Default handler.
  input wire logic                 fast_irq_out,     // Fast request.
  input wire logic                 normal_irq_out,   // Normal request.
  input wire vint_pkg::vint_addr_t vec_addr_out,     // Vector word.
  input wire logic                 vec_active_out,   // Slot winning.
  input wire vint_pkg::vint_chan_t fast_status_out,  // Fast status.
  input wire vint_pkg::vint_chan_t normal_status_out // Normal status.
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // The controller sees the soft channel from its own input, never from the link.
  logic [31:0] raw;
  assign raw = {req_in[31:2], soft_req_in, req_in[0]};
  sequence s_fast_req; |(raw & fast_select_in); endsequence
  sequence s_fast_gone; fast_irq_out ##1 !(|(raw & fast_select_in)); endsequence
  a_fast_merge: assert property (s_fast_req |=> fast_irq_out)
    else $error("fast request not merged");
  a_fast_drop: assert property (s_fast_gone |=> !fast_irq_out)
    else $error("fast request held too long");
  a_fast_status: assert property (!$past(reset_in) |->
    fast_status_out == $past(raw & fast_select_in)) else $error("fast status wrong");
  a_normal_status: assert property (!$past(reset_in) |->
    normal_status_out == $past(raw & ~fast_select_in)) else $error("normal status wrong");
  a_class_excl: assert property ((fast_status_out & normal_status_out) == '0)
    else $error("channel in two classes");
  a_normal_merge: assert property (normal_irq_out == |normal_status_out)
    else $error("normal request wrong");
  a_vec_normal: assert property (vec_active_out |-> normal_irq_out)
    else $error("vector without normal request");
  a_default_addr: assert property (!$past(reset_in) && !vec_active_out |->
    vec_addr_out == $past(default_addr_in)) else $error("default address wrong");
  a_soft_free: assert property (req_in[1] == 1'b0)
    else $error("soft channel driven by peripheral");
  a_spare_zero: assert property (req_in[31:19] == '0)
    else $error("unused channel driven");
endmodule : vint_link_sva

//--- bench/vectored_interrupt_controller_tb.sv
// Testbench: peripheral end joined to the controller end through the link.
// Assumes package, header and interface are compiled before this file.
`timescale 1ns/1ps

module vectored_interrupt_controller_tb;
  logic                     clock_in = 1'b0;
  logic                     reset_in = 1'b1;
  logic [31:0]              misc_req = '0;
  logic [25:0]              flags = '0;
  logic                     soft_req = 1'b0;
  vint_pkg::vint_chan_t     fast_select = '0;
  logic [15:0]              slot_enable = '0;
  vint_pkg::vint_chan_idx_t slot_chan [16];
  vint_pkg::vint_addr_t     slot_addr [16];
  vint_pkg::vint_addr_t     default_addr = 32'hdef0_0000;
  logic                     fast_irq, normal_irq, vec_active;
  vint_pkg::vint_addr_t     vec_addr;
  vint_pkg::vint_slot_idx_t vec_slot;
  vint_pkg::vint_chan_t     fast_status, normal_status;
  int                       errors = 0;
  int                       comparisons = 0;

  vint_if link_if ();
  vint_src u_vint_src (.clock_in(clock_in), .reset_in(reset_in), .misc_req_in(misc_req),
    .timer0_match_in(flags[3:0]), .serial0_flags_in(flags[7:4]),
    .serial1_flags_in(flags[12:8]), .pwm_match_in(flags[19:13]),
    .rtc_flags_in(flags[21:20]), .ext_irq_lines_in(flags[25:22]), .link(link_if));
  vint_ctrl u_vint_ctrl (.clock_in(clock_in), .reset_in(reset_in), .link(link_if),
    .soft_req_in(soft_req), .fast_select_in(fast_select), .slot_enable_in(slot_enable),
    .slot_chan_in(slot_chan), .slot_addr_in(slot_addr), .default_addr_in(default_addr),
    .fast_irq_out(fast_irq), .normal_irq_out(normal_irq), .vec_addr_out(vec_addr),
    .vec_active_out(vec_active), .vec_slot_out(vec_slot),
    .fast_status_out(fast_status), .normal_status_out(normal_status));
  vint_link_sva u_sva (.clock_in(clock_in), .reset_in(reset_in), .req_in(link_if.req),
    .soft_req_in(soft_req), .fast_select_in(fast_select), .default_addr_in(default_addr),
    .fast_irq_out(fast_irq), .normal_irq_out(normal_irq), .vec_addr_out(vec_addr),
    .vec_active_out(vec_active), .fast_status_out(fast_status),
    .normal_status_out(normal_status));

  always #2.5 clock_in = ~clock_in;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask : step

  function automatic int chan_of(input int i);
    if (i < 4) return 4;
    if (i < 8) return 6;
    if (i < 13) return 7;
    if (i < 20) return 8;
    if (i < 22) return 13;
    return i - 8;
  endfunction : chan_of

  initial begin
    for (int i = 0; i < 16; i++) begin
      slot_chan[i] = 5'h03;
      slot_addr[i] = 32'ha000_0000 + 32'(i * 4);
    end
    step(5);
    reset_in = 1'b0;
    // External pins pass two sync stages, so they need two more cycles.
    for (int i = 0; i < 26; i++) begin
      flags = 26'h1 << i;
      step(i < 22 ? 2 : 4);
      check(normal_status, 32'h1 << chan_of(i));
      flags = '0;
      step(4);
    end
    $display("channel map test done");
    misc_req = 32'hffff_ffff;
    step(2);
    check(normal_status, 32'h0004_1e2d);
    soft_req = 1'b1;
    step(1);
    check(normal_status, 32'h0004_1e2f);
    soft_req = 1'b0;
    misc_req = 32'h0000_0009;
    for (int k = 0; k < 16; k++) begin
      slot_enable = 16'hffff << k;
      step(2);
      check(vec_addr, 32'ha000_0000 + 32'(k * 4));
      check({27'h0, vec_active, vec_slot}, 32'h0000_0010 | 32'(k));
    end
    $display("slot priority test done");
    fast_select = 32'h0000_0009;
    step(1);
    check(vec_addr, default_addr);
    check({29'h0, fast_irq, normal_irq, vec_active}, 32'h4);
    check(fast_status, 32'h0000_0009);
    fast_select = 32'h0;
    slot_chan[5] = 5'h00;
    slot_enable = 16'h0020;
    step(1);
    check(vec_addr, 32'ha000_0014);
    slot_enable = 16'h0;
    step(1);
    check(vec_addr, default_addr);
    check(normal_status, 32'h0000_0009);
    $display("class test done");
    summarize();
  end

  // Whole run needs about 207 cycles; this limit leaves ample room.
  initial begin
    step(3000);
    errors++;
    summarize();
  end
endmodule : vectored_interrupt_controller_tb
